//--- bench/ldh_ctrl_tb.sv
/*
 self-checking bench for the lock detect and holdover controller.
 assumes the phase detector model and the checker are compiled alongside.
*/
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin err_total++; \
	$display("wrong value %s exp %0h got %0h", nm, ex, got); end end
module ldh_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ldh_pkg::*;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, ref_valid = 0, fire = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic lock_indicator, holdover_active, tuning_hold;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [9:0] tuning_sense = 0, tuning_code, dac_level, code;
	logic signed [15:0] err_cmd = 0;
	logic [33:0] e;
	ldh_cmp_t cmp;
	logic [1:0] bq[$];
	logic [33:0] rq[$];
	int err_total = 0, n_checks = 0;
	ldh_ctrl u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp, .ref_valid, .tuning_sense,
		.lock_indicator, .holdover_active, .tuning_hold, .tuning_code);
	ldh_pd_model u_pd (.aclk, .fire, .err_cmd, .cmp, .tuning_hold, .tuning_code, .dac_level);
	initial begin
		forever #12.5 aclk = ~aclk;
	end
	task give_verdict;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : give_verdict
	always @(negedge aclk) begin
		if (s_axi_bvalid && s_axi_bready) begin
			e = 34'(bq.pop_front());
			`CHK("bresp", e[1:0], s_axi_bresp)
		end
		if (s_axi_rvalid && s_axi_rready) begin
			e = rq.pop_front();
			`CHK("rresp", e[33:32], s_axi_rresp)
			`CHK("rdata", e[31:0], s_axi_rdata)
		end
	end
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic ta, tw;
		bq.push_back(r);
		ta = 0;
		tw = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ta && tw)) begin
			@(negedge aclk);
			ta |= s_axi_awvalid & s_axi_awready;
			tw |= s_axi_wvalid & s_axi_wready;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end
		do @(negedge aclk); while (!s_axi_bvalid);
		@(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [33:0] x);
		rq.push_back(x);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(negedge aclk); while (!s_axi_arready);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		do @(negedge aclk); while (!s_axi_rvalid);
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask : rd
	task pulse(input int n, input logic signed [15:0] er);
		repeat (n) begin
			@(posedge aclk);
			fire <= 1'b1;
			err_cmd <= er;
			@(posedge aclk);
			fire <= 1'b0;
		end
		repeat (3) @(posedge aclk);
	endtask : pulse
	function automatic logic signed [15:0] inw();
		return 16'($urandom % 9) - 16'h4;
	endfunction : inw
	initial begin
		void'($urandom(10));
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'h00, 34'h0);
		rd(8'h04, 34'h4);
		rd(8'h08, 34'h2710);
		rd(8'h0C, 34'h200);
		rd(8'h14, 34'h200);
		rd(8'h18, {2'h2, 32'h0});
		wr(8'h10, 32'h1, 2'h2);
		@(negedge aclk);
		`CHK("code", 10'h200, tuning_code)
		code = 10'($urandom);
		wr(8'h0C, {22'h0, code}, 2'h0);
		rd(8'h0C, {24'h0, code});
		wr(8'h08, 32'h5, 2'h0);
		tuning_sense <= 10'($urandom);
		for (int k = 0; k < 3; k++) begin
			wr(8'h00, k == 0 ? 32'hA : (k == 1 ? 32'h1A : 32'hC), 2'h0);
			pulse(4, inw());
			pulse(1, 16'h40 + 16'($urandom % 64));
			pulse(4, inw());
			rd(8'h10, 34'h0);
			pulse(1, inw());
			rd(8'h10, 34'h5);
			@(negedge aclk);
			`CHK("lock", 1'b1, lock_indicator)
			rd(8'h14, k == 2 ? {24'h0, tuning_sense} : 34'h200);
			pulse(1, -16'sd5);
			rd(8'h10, k ? 34'h0 : 34'hA);
			@(negedge aclk);
			`CHK("unlock", 1'b0, lock_indicator)
			`CHK("hold", 1'(k == 0), holdover_active)
			if (k == 0) begin
				`CHK("pin", 1'b1, tuning_hold)
				`CHK("code", code, tuning_code)
				`CHK("dac", code, dac_level)
				pulse(6, inw());
				rd(8'h10, 34'hA);
				wr(8'h0C, 32'h200, 2'h0);
				repeat (3) @(posedge aclk);
				@(negedge aclk);
				`CHK("mid", 10'h200, dac_level)
				@(posedge aclk);
				ref_valid <= 1'b1;
				repeat (4) @(posedge aclk);
				rd(8'h10, 34'h0);
				ref_valid <= 1'b0;
				@(negedge aclk);
				`CHK("left", 1'b0, holdover_active)
			end
		end
		give_verdict;
	end
	initial begin
		repeat (20000) @(posedge aclk);
		err_total++;
		give_verdict;
	end
endmodule : ldh_ctrl_tb
bind ldh_ctrl ldh_monitor u_mon (.aclk(aclk), .aresetn(aresetn), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.cmp(cmp), .ref_valid(ref_valid), .lock_indicator(lock_indicator),
	.holdover_active(holdover_active), .tuning_hold(tuning_hold));

//--- bench/ldh_monitor.sv
/*
 checker for the lock detect and holdover controller ports.
 assumes binding to ldh_ctrl from the bench top file.
*/
module ldh_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire ldh_pkg::ldh_cmp_t cmp,
	input wire logic ref_valid,
	input wire logic lock_indicator,
	input wire logic holdover_active,
	input wire logic tuning_hold
);
	timeunit 1ns;
	timeprecision 1ps;
	import ldh_pkg::*;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	lock_rise_a: assert property ($rose(lock_indicator) |-> $past(cmp.valid))
		else $error("lock rose without a comparison");
	lock_fall_a: assert property ($fell(lock_indicator) |-> $past(cmp.valid))
		else $error("lock fell without a comparison");
	hold_entry_a: assert property ($rose(holdover_active) |-> !lock_indicator &&
		($past(lock_indicator) || $past(lock_indicator, 2) || $past(lock_indicator, 3)))
		else $error("holdover began without lock loss");
	hold_exit_a: assert property (holdover_active && ref_valid |-> ##[1:3] !holdover_active)
		else $error("holdover kept with reference present");
	hold_nolock_a: assert property (holdover_active |-> !lock_indicator)
		else $error("lock high in holdover");
	hold_pin_a: assert property (tuning_hold == holdover_active)
		else $error("tuning hold differs from holdover");
	ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
		else $error("arready wrong");
	err_data_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
		else $error("error read carries data");
	cover property ($rose(lock_indicator));
	cover property ($rose(holdover_active));
	cover property ($fell(holdover_active));
endmodule : ldh_monitor

//--- bench/ldh_pd_model.sv
/*
 phase detector and tuning dac model of the cleaner loop.
 assumes one comparison per fire pulse; dac follows code while held.
*/
module ldh_pd_model (
	input wire logic aclk,
	input wire logic fire,
	input wire logic signed [15:0] err_cmd,
	output ldh_pkg::ldh_cmp_t cmp,
	input wire logic tuning_hold,
	input wire logic [9:0] tuning_code,
	output logic [9:0] dac_level
);
	timeunit 1ns;
	timeprecision 1ps;
	import ldh_pkg::*;
	initial begin
		cmp = '0;
		dac_level = 10'h000;
	end
	always @(posedge aclk) begin
		cmp.valid <= fire;
		// idle error keeps toggling
		cmp.error <= fire ? err_cmd : ~cmp.error;
		if (tuning_hold) begin
			dac_level <= tuning_code;
		end
	end
endmodule : ldh_pd_model

//--- src/ldh_cfg.svh
/*
 lock detect and holdover constants: register offsets, field positions, reset values.
 assumes inclusion by the lock detect controller; its phase window comparator does not include it.
*/
`ifndef LDH_CFG_SVH
`define LDH_CFG_SVH

`define LDH_CLK_HZ 40000000
`define LDH_ADDR_W 8
`define LDH_OFF_CTRL 8'h00
`define LDH_OFF_WINDOW 8'h04
`define LDH_OFF_COUNT 8'h08
`define LDH_OFF_DAC 8'h0C
`define LDH_OFF_STATUS 8'h10
`define LDH_OFF_TRACK 8'h14
`define LDH_CTRL_MODE_LSB 0
`define LDH_CTRL_TRACK_BIT 2
`define LDH_CTRL_MANDAC_BIT 3
`define LDH_CTRL_DISDET_BIT 4
`define LDH_CTRL_RESET 32'h0000_0000
`define LDH_MODE_HOLDOVER 2'h2
`define LDH_WINDOW_RESET 8'h04
`define LDH_COUNT_RESET 14'h2710
`define LDH_DAC_RESET 10'h200
`define LDH_RESP_OKAY 2'h0
`define LDH_RESP_SLVERR 2'h2

`endif

//--- src/ldh_ctrl.sv
/*
 lock detector and holdover controller for the cleaner loop, with an AXI4-Lite register slave.
 assumes the phase detector reports one comparison per cmp.valid, the reference-valid level is
 synchronous to aclk, and the tuning DAC takes tuning_code whenever tuning_hold is high.
*/
// The AXI4-Lite interface to the registers and the address map were decided locally.
`include "ldh_cfg.svh"

module ldh_ctrl #(
	parameter int ERR_W = 16,
	parameter int WIN_W = 8,
	parameter int CNT_W = 14,
	parameter int DAC_W = 10
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [`LDH_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`LDH_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire ldh_pkg::ldh_cmp_t cmp,
	input wire logic ref_valid,
	input wire logic [DAC_W-1:0] tuning_sense,
	output logic lock_indicator,
	output logic holdover_active,
	output logic tuning_hold,
	output logic [DAC_W-1:0] tuning_code
);
	import ldh_pkg::*;

	ldh_state_t state_r;
	ldh_ctrl_t ctrl_r;
	logic [WIN_W-1:0] window_r;
	logic [CNT_W-1:0] count_target_r;
	logic [DAC_W-1:0] manual_code_r;
	logic [DAC_W-1:0] track_code_r;
	logic [CNT_W-1:0] run_cnt_r;
	logic [CNT_W-1:0] run_cnt_nxt;
	logic lock_r;
	logic lock_nxt;
	logic in_window;
	logic [`LDH_ADDR_W-1:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic aw_have_r;
	logic w_have_r;
	logic wr_fire;
	logic rd_fire;
	logic holdover_en;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	ldh_window #(.ERR_W(ERR_W), .WIN_W(WIN_W)) u_window (
		.phase_error(cmp.error),
		.phase_window_width(window_r),
		.in_window(in_window)
	);

	// write channel: address and data taken in either order
	assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
	assign s_axi_wready = !w_have_r && !s_axi_bvalid;
	assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `LDH_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (awaddr_r)
					`LDH_OFF_CTRL, `LDH_OFF_WINDOW, `LDH_OFF_COUNT, `LDH_OFF_DAC: begin
						s_axi_bresp <= `LDH_RESP_OKAY;
					end
					default: begin
						s_axi_bresp <= `LDH_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// configuration registers
	always_ff @(posedge aclk) begin
		logic [31:0] v;
		v = '0;
		if (!aresetn) begin
			ctrl_r <= '0;
			window_r <= `LDH_WINDOW_RESET;
			count_target_r <= `LDH_COUNT_RESET;
			manual_code_r <= `LDH_DAC_RESET;
		end else if (wr_fire) begin
			case (awaddr_r)
				`LDH_OFF_CTRL: begin
					v = merge({27'h0, ctrl_r.lockloss_holdover_disable,
						ctrl_r.manual_tuning_enable, ctrl_r.track_en, ctrl_r.mode},
						wdata_r, wstrb_r);
					ctrl_r.mode <= v[`LDH_CTRL_MODE_LSB +: 2];
					ctrl_r.track_en <= v[`LDH_CTRL_TRACK_BIT];
					ctrl_r.manual_tuning_enable <= v[`LDH_CTRL_MANDAC_BIT];
					ctrl_r.lockloss_holdover_disable <= v[`LDH_CTRL_DISDET_BIT];
				end
				`LDH_OFF_WINDOW: begin
					v = merge(32'(window_r), wdata_r, wstrb_r);
					window_r <= v[WIN_W-1:0];
				end
				`LDH_OFF_COUNT: begin
					v = merge(32'(count_target_r), wdata_r, wstrb_r);
					count_target_r <= v[CNT_W-1:0];
				end
				`LDH_OFF_DAC: begin
					v = merge(32'(manual_code_r), wdata_r, wstrb_r);
					manual_code_r <= v[DAC_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// read channel
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= `LDH_RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `LDH_RESP_OKAY;
			case (s_axi_araddr)
				`LDH_OFF_CTRL: begin
					s_axi_rdata <= {27'h0, ctrl_r.lockloss_holdover_disable,
						ctrl_r.manual_tuning_enable, ctrl_r.track_en, ctrl_r.mode};
				end
				`LDH_OFF_WINDOW: s_axi_rdata <= 32'(window_r);
				`LDH_OFF_COUNT: s_axi_rdata <= 32'(count_target_r);
				`LDH_OFF_DAC: s_axi_rdata <= 32'(manual_code_r);
				`LDH_OFF_STATUS: s_axi_rdata <= {28'h0, state_r, holdover_active, lock_r};
				`LDH_OFF_TRACK: s_axi_rdata <= 32'(track_code_r);
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `LDH_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// consecutive in-window counting and lock decision
	always_comb begin
		run_cnt_nxt = run_cnt_r;
		lock_nxt = lock_r;
		if (state_r == LDH_HOLDOVER) begin
			run_cnt_nxt = '0;
			lock_nxt = 1'b0;
		end else if (cmp.valid) begin
			if (!in_window) begin
				run_cnt_nxt = '0;
				lock_nxt = 1'b0;
			end else if (run_cnt_r < count_target_r) begin
				run_cnt_nxt = run_cnt_r + CNT_W'(1);
			end
			if (in_window && (run_cnt_nxt >= count_target_r)) begin
				lock_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_cnt_r <= '0;
			lock_r <= 1'b0;
		end else begin
			run_cnt_r <= run_cnt_nxt;
			lock_r <= lock_nxt;
		end
	end

	assign holdover_en = (ctrl_r.mode == `LDH_MODE_HOLDOVER);

	// holdover state machine
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= LDH_ACQUIRE;
		end else begin
			case (state_r)
				LDH_ACQUIRE: begin
					if (lock_nxt) begin
						state_r <= LDH_LOCKED;
					end
				end
				LDH_LOCKED: begin
					if (!lock_nxt) begin
						if (holdover_en && !ctrl_r.lockloss_holdover_disable) begin
							state_r <= LDH_HOLDOVER;
						end else begin
							state_r <= LDH_ACQUIRE;
						end
					end
				end
				LDH_HOLDOVER: begin
					if (ref_valid || !holdover_en) begin
						state_r <= LDH_ACQUIRE;
					end
				end
				default: state_r <= LDH_ACQUIRE;
			endcase
		end
	end

	// tuning voltage tracking while locked
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			track_code_r <= `LDH_DAC_RESET;
		end else if (state_r == LDH_LOCKED && ctrl_r.track_en) begin
			track_code_r <= tuning_sense;
		end
	end

	// holdover tuning drive
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tuning_code <= `LDH_DAC_RESET;
			tuning_hold <= 1'b0;
			holdover_active <= 1'b0;
		end else begin
			holdover_active <= (state_r == LDH_HOLDOVER);
			tuning_hold <= (state_r == LDH_HOLDOVER);
			if (ctrl_r.manual_tuning_enable) begin
				tuning_code <= manual_code_r;
			end else begin
				tuning_code <= track_code_r;
			end
		end
	end

	assign lock_indicator = lock_r;
endmodule : ldh_ctrl

//--- src/ldh_pkg.sv
/*
 types for the lock detect and holdover controller.
 assumes ldh_cfg.svh is compiled alongside.
*/
package ldh_pkg;
	typedef enum logic [1:0] {
		LDH_ACQUIRE = 2'h0,
		LDH_LOCKED = 2'h1,
		LDH_HOLDOVER = 2'h2
	} ldh_state_t;

	typedef struct packed {
		logic valid;
		logic signed [15:0] error;
	} ldh_cmp_t;

	typedef struct packed {
		logic [1:0] mode;
		logic track_en;
		logic manual_tuning_enable;
		logic lockloss_holdover_disable;
	} ldh_ctrl_t;
endpackage : ldh_pkg

//--- src/ldh_window.sv
/*
 phase window comparator: flags a comparison whose error magnitude lies inside the window.
 assumes one comparison result per valid pulse from the cleaner loop phase detector.
*/
module ldh_window #(
	parameter int ERR_W = 16,
	parameter int WIN_W = 8
) (
	input wire logic signed [ERR_W-1:0] phase_error,
	input wire logic [WIN_W-1:0] phase_window_width,
	output logic in_window
);
	logic [ERR_W-1:0] mag;

	always_comb begin
		mag = phase_error[ERR_W-1] ? ERR_W'(-phase_error) : ERR_W'(phase_error);
		in_window = (mag <= ERR_W'(phase_window_width));
	end
endmodule : ldh_window
